// file: dsb_sram_ctl.sv
/*
  controller end: makes the input and output strobes from mclk by a
  divide-by-four, loads one address per strobe period and moves the
  two-word bursts. assumes the device answers reads one period later.
*/
`timescale 1ns/1ns
module dsb_sram_ctl
  import dsb_pkg::*;
#(
  parameter int DATA_W = DSB_DATA_W,
  parameter int ADDR_W = DSB_ADDR_W
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  dsb_link_if.ctl link,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata0_in,
  input wire logic [DATA_W-1:0] req_wdata1_in,
  input wire logic [dsb_lanes(DATA_W)-1:0] req_wsel0_n_in,
  input wire logic [dsb_lanes(DATA_W)-1:0] req_wsel1_n_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_W-1:0] rd_data0_out,
  output logic [DATA_W-1:0] rd_data1_out
);
  localparam int NSEL = dsb_lanes(DATA_W);
  localparam bit NIB_VAR = (DATA_W == DSB_NIBBLE_VARIANT_W);

  dsb_phase_t phase;
  dsb_phase_t next_phase;
  logic take;
  logic slot_read;
  logic wr_pend;
  logic [DATA_W-1:0] wd0;
  logic [DATA_W-1:0] wd1;
  logic [DATA_W-1:0] cur_wd1;
  logic [NSEL-1:0] ws0;
  logic [NSEL-1:0] ws1;
  logic [NSEL-1:0] cur_ws1;
  logic rs1;
  logic rs2;
  logic rs3;
  logic [DSB_BYTE_SEL-1:0] byte_idle;
  logic [DSB_BYTE_SEL-1:0] byte_w0;
  logic [DSB_BYTE_SEL-1:0] byte_w1;

  assign next_phase = phase + DSB_PH_STEP;
  assign take = req_ready_out & req_valid_in;
  assign byte_idle = '1;
  // lanes beyond the variant width stay deselected
  assign byte_w0 = DSB_BYTE_SEL'(ws0) | ~DSB_BYTE_SEL'({NSEL{1'b1}});
  assign byte_w1 = DSB_BYTE_SEL'(cur_ws1) | ~DSB_BYTE_SEL'({NSEL{1'b1}});

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase <= DSB_PH_LAST;
      link.strobe_k <= 1'b0;
      link.strobe_kb <= 1'b1;
      link.strobe_c <= 1'b0;
      link.strobe_cb <= 1'b1;
      req_ready_out <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      link.strobe_k <= (next_phase == DSB_PH_K) || (next_phase == DSB_PH_K_HOLD);
      link.strobe_kb <= (next_phase == DSB_PH_KB) || (next_phase == DSB_PH_LAST);
      link.strobe_c <= (next_phase == DSB_PH_K) || (next_phase == DSB_PH_K_HOLD);
      link.strobe_cb <= (next_phase == DSB_PH_KB) || (next_phase == DSB_PH_LAST);
      // one idle slot after a read keeps the turnaround free of contention
      req_ready_out <= (next_phase == DSB_PH_LAST) && !slot_read;
    end
  end

  // load, direction and address change only at the start of a period
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link.load_n <= 1'b1;
      link.read_not_write <= 1'b1;
      link.addr <= '0;
      slot_read <= 1'b0;
    end
    else if (phase == DSB_PH_LAST)
    begin
      link.load_n <= ~take;
      slot_read <= take & ~req_write_in;
      if (take)
      begin
        link.read_not_write <= ~req_write_in;
        link.addr <= req_addr_in;
      end
    end
  end

  // write burst: word0 with the next k rise, word1 with the kb rise
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_pend <= 1'b0;
      wd0 <= '0;
      wd1 <= '0;
      ws0 <= '1;
      ws1 <= '1;
      cur_wd1 <= '0;
      cur_ws1 <= '1;
      link.ctl_dq <= '0;
      link.ctl_dq_oe <= 1'b0;
      link.nibble_write_sel_n <= '1;
      link.byte_write_sel_n <= '1;
    end
    else if (phase == DSB_PH_LAST)
    begin
      wr_pend <= take & req_write_in;
      wd0 <= req_wdata0_in;
      wd1 <= req_wdata1_in;
      ws0 <= req_wsel0_n_in;
      ws1 <= req_wsel1_n_in;
      cur_wd1 <= wd1;
      cur_ws1 <= ws1;
      link.ctl_dq_oe <= wr_pend;
      link.ctl_dq <= wd0;
      if (wr_pend && NIB_VAR)
      begin
        link.nibble_write_sel_n <= DSB_NIB_SEL'(ws0);
        link.byte_write_sel_n <= byte_idle;
      end
      else if (wr_pend)
      begin
        link.nibble_write_sel_n <= '1;
        link.byte_write_sel_n <= byte_w0;
      end
      else
      begin
        link.nibble_write_sel_n <= '1;
        link.byte_write_sel_n <= byte_idle;
      end
    end
    else if ((phase == DSB_PH_K_HOLD) && link.ctl_dq_oe)
    begin
      link.ctl_dq <= cur_wd1;
      link.nibble_write_sel_n <= NIB_VAR ? DSB_NIB_SEL'(cur_ws1) : 2'h3;
      link.byte_write_sel_n <= NIB_VAR ? byte_idle : byte_w1;
    end
  end

  // read burst: word0 sampled from the pins at the kb phase of the period after the load, word1 at the k phase after it
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
      rs3 <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data0_out <= '0;
      rd_data1_out <= '0;
    end
    else
    begin
      rd_valid_out <= 1'b0;
      if (phase == DSB_PH_LAST)
      begin
        rs1 <= take & ~req_write_in;
        rs2 <= rs1;
      end
      if ((phase == DSB_PH_KB) && rs2)
      begin
        rd_data0_out <= link.dq_bus;
        rs3 <= 1'b1;
      end
      if ((phase == DSB_PH_K) && rs3)
      begin
        rd_data1_out <= link.dq_bus;
        rd_valid_out <= 1'b1;
        rs3 <= 1'b0;
      end
    end
  end
endmodule

// file: dsb_pkg.sv
/*
  shared constants, types and helpers for the two-word burst ddr sram port.
  assumes both ends and the link interface import it whole.
*/
package dsb_pkg;

  // documented variant defaults: 1M x 18
  localparam int DSB_DATA_W = 18;
  localparam int DSB_ADDR_W = 20;

  // write-select lanes
  localparam int DSB_NIB_W = 4;
  localparam int DSB_BYTE_W = 9;
  localparam int DSB_NIB_SEL = 2;
  localparam int DSB_BYTE_SEL = 4;
  localparam int DSB_NIBBLE_VARIANT_W = 8;
  localparam int DSB_NARROW_MAX_W = 9;
  localparam int DSB_BURST_LEN = 2;

  // the controller splits one strobe period into four mclk phases
  typedef logic [1:0] dsb_phase_t;
  localparam dsb_phase_t DSB_PH_K = 2'h0;
  localparam dsb_phase_t DSB_PH_K_HOLD = 2'h1;
  localparam dsb_phase_t DSB_PH_KB = 2'h2;
  localparam dsb_phase_t DSB_PH_LAST = 2'h3;
  localparam dsb_phase_t DSB_PH_STEP = 2'h1;

  function automatic int dsb_lane_w(input int dw);
    dsb_lane_w = (dw == DSB_NIBBLE_VARIANT_W) ? DSB_NIB_W : DSB_BYTE_W;
  endfunction

  function automatic int dsb_lanes(input int dw);
    dsb_lanes = (dw + dsb_lane_w(dw) - 1) / dsb_lane_w(dw);
  endfunction

endpackage

// file: dsb_link_if.sv
/*
  pin-level link between the memory controller and the sram device.
  assumes one shared mclk; the shared data pins are resolved here from
  the device output enable alone, the device winning if both drive.
*/
`timescale 1ns/1ns
interface dsb_link_if
  import dsb_pkg::*;
#(
  parameter int DATA_W = DSB_DATA_W,
  parameter int ADDR_W = DSB_ADDR_W
);
  logic strobe_k;
  logic strobe_kb;
  logic strobe_c;
  logic strobe_cb;
  logic load_n;
  logic read_not_write;
  logic [ADDR_W-1:0] addr;
  logic [DSB_NIB_SEL-1:0] nibble_write_sel_n;
  logic [DSB_BYTE_SEL-1:0] byte_write_sel_n;
  logic [DATA_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DATA_W-1:0] dq_bus;

  assign dq_bus = dev_dq_oe ? dev_dq : ctl_dq;

  modport dev (
    input strobe_k, strobe_kb, strobe_c, strobe_cb, load_n, read_not_write, addr,
    input nibble_write_sel_n, byte_write_sel_n, dq_bus,
    output dev_dq, dev_dq_oe
  );

  modport ctl (
    output strobe_k, strobe_kb, strobe_c, strobe_cb, load_n, read_not_write, addr,
    output nibble_write_sel_n, byte_write_sel_n, ctl_dq, ctl_dq_oe,
    input dq_bus
  );
endinterface

// file: dsb_sram_dev.sv
/*
  device end: the two-word burst ddr sram port and its storage array.
  assumes strobes, load, address and masks arrive synchronous to mclk and
  that the controller presents each word in the cycle its strobe rises.
*/
`timescale 1ns/1ns
module dsb_sram_dev
  import dsb_pkg::*;
#(
  parameter int DATA_W = DSB_DATA_W,
  parameter int ADDR_W = DSB_ADDR_W
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  dsb_link_if.dev link,
  input wire logic single_clock_mode_in
);
  localparam int LANE_W = dsb_lane_w(DATA_W);
  localparam bit NARROW = (DATA_W <= DSB_NARROW_MAX_W);
  // narrow parts add an internal word bit below the pins
  localparam int IAW = NARROW ? ADDR_W + 1 : ADDR_W;
  localparam int DEPTH = 2 ** IAW;

  // large default depth; shrink ADDR_W for quick simulation
  logic [DATA_W-1:0] mem [0:DEPTH-1];

  logic k_d;
  logic kb_d;
  logic c_d;
  logic cb_d;
  logic wr_armed;
  logic wr_second;
  logic [IAW-1:0] wr_addr;
  logic [IAW-1:0] wr_addr2;
  logic rd_armed;
  logic rd_second;
  logic [IAW-1:0] rd_addr;
  logic [IAW-1:0] rd_addr2;

  wire k_rise;
  wire kb_rise;
  wire out_p_rise;
  wire out_n_rise;
  wire load_hit;
  wire burst_start_bit;
  wire [IAW-1:0] load_addr;
  wire wr_word0;
  wire wr_word1;
  wire wr_en;
  wire [IAW-1:0] wr_now_addr;
  wire [DATA_W-1:0] lane_bits;
  wire [DATA_W-1:0] merged;

  // the pair wraps inside its aligned two-word block
  function automatic logic [IAW-1:0] next_word_addr(input logic [IAW-1:0] a);
    next_word_addr = {a[IAW-1:1], ~a[0]};
  endfunction

  // active-low selects widened to one enable bit per data bit
  function automatic logic [DATA_W-1:0] lane_enable(
    input logic [DSB_BYTE_SEL-1:0] bsel_n,
    input logic [DSB_NIB_SEL-1:0] nsel_n
  );
    int lane;
    lane_enable = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      lane = i / LANE_W;
      if (DATA_W == DSB_NIBBLE_VARIANT_W)
        lane_enable[i] = ~nsel_n[lane[0]];
      else
        lane_enable[i] = ~bsel_n[lane[1:0]];
    end
  endfunction

  assign k_rise = link.strobe_k & ~k_d;
  assign kb_rise = link.strobe_kb & ~kb_d;
  // without output strobes the input pair clocks the read data out
  assign out_p_rise = single_clock_mode_in ? k_rise : (link.strobe_c & ~c_d);
  assign out_n_rise = single_clock_mode_in ? kb_rise : (link.strobe_cb & ~cb_d);
  assign load_hit = k_rise & ~link.load_n;

  generate
    if (NARROW)
    begin : g_narrow
      assign burst_start_bit = 1'b0;
      assign load_addr = {link.addr, burst_start_bit};
    end
    else
    begin : g_wide
      assign burst_start_bit = link.addr[0];
      assign load_addr = {link.addr[ADDR_W-1:1], burst_start_bit};
    end
  endgenerate

  assign wr_word0 = k_rise & wr_armed;
  assign wr_word1 = kb_rise & wr_second;
  assign wr_en = wr_word0 | wr_word1;
  assign wr_now_addr = wr_word0 ? wr_addr : wr_addr2;
  assign lane_bits = lane_enable(link.byte_write_sel_n, link.nibble_write_sel_n);
  // deselected lanes take the stored bits back unchanged
  assign merged = (link.dq_bus & lane_bits) | (mem[wr_now_addr] & ~lane_bits);

  always_ff @(posedge mclk_in)
  begin
    if (wr_en)
      mem[wr_now_addr] <= merged;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      // history starts at the idle strobe levels, so no false rise follows reset
      k_d <= 1'b0;
      kb_d <= 1'b1;
      c_d <= 1'b0;
      cb_d <= 1'b1;
    end
    else
    begin
      k_d <= link.strobe_k;
      kb_d <= link.strobe_kb;
      c_d <= link.strobe_c;
      cb_d <= link.strobe_cb;
    end
  end

  // write side: word0 on the k rise after the load, word1 on the next kb rise
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_armed <= 1'b0;
      wr_second <= 1'b0;
      wr_addr <= '0;
      wr_addr2 <= '0;
    end
    else
    begin
      if (k_rise)
        wr_armed <= load_hit & ~link.read_not_write;
      if (load_hit && !link.read_not_write)
        wr_addr <= load_addr;
      if (wr_word0)
      begin
        wr_addr2 <= next_word_addr(wr_addr);
        wr_second <= 1'b1;
      end
      else if (wr_word1)
        wr_second <= 1'b0;
    end
  end

  // read side: drivers follow the output strobes, off once the pair is out
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_armed <= 1'b0;
      rd_second <= 1'b0;
      rd_addr <= '0;
      rd_addr2 <= '0;
      link.dev_dq <= '0;
      link.dev_dq_oe <= 1'b0;
    end
    else
    begin
      if (out_p_rise)
      begin
        link.dev_dq_oe <= rd_armed;
        rd_second <= rd_armed;
        rd_armed <= 1'b0;
        if (rd_armed)
        begin
          link.dev_dq <= mem[rd_addr];
          rd_addr2 <= next_word_addr(rd_addr);
        end
      end
      else if (out_n_rise && rd_second)
      begin
        link.dev_dq <= mem[rd_addr2];
        rd_second <= 1'b0;
      end
      // a load on the same edge is served on the following output rise
      if (load_hit && link.read_not_write)
      begin
        rd_armed <= 1'b1;
        rd_addr <= load_addr;
      end
    end
  end
endmodule

// file: dsb_link_asserts.sv
/*
  concurrent checks on the controller-to-device link.
  assumes the bench ties it to the link signals and both ends share mclk.
*/
`timescale 1ns/1ns
module dsb_link_asserts
  import dsb_pkg::*;
#(
  parameter int DATA_W = DSB_DATA_W
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic strobe_k,
  input wire logic strobe_kb,
  input wire logic strobe_c,
  input wire logic strobe_cb,
  input wire logic load_n,
  input wire logic read_not_write,
  input wire logic [DSB_NIB_SEL-1:0] nibble_write_sel_n,
  input wire logic [DSB_BYTE_SEL-1:0] byte_write_sel_n,
  input wire logic [DATA_W-1:0] ctl_dq,
  input wire logic ctl_dq_oe,
  input wire logic [DATA_W-1:0] dev_dq,
  input wire logic dev_dq_oe
);
  logic k_q;
  logic kb_q;
  logic c_q;
  logic cb_q;
  wire k_rise = strobe_k & ~k_q;
  wire kb_rise = strobe_kb & ~kb_q;
  wire out_rise = (strobe_c & ~c_q) | (strobe_cb & ~cb_q);
  wire wr_load = k_rise & ~load_n & ~read_not_write;
  wire rd_load = k_rise & ~load_n & read_not_write;

  // edge history only, so strobe rises can be seen as one-cycle events
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      k_q <= 1'b0;
      kb_q <= 1'b1;
      c_q <= 1'b0;
      cb_q <= 1'b1;
    end
    else
    begin
      k_q <= strobe_k;
      kb_q <= strobe_kb;
      c_q <= strobe_c;
      cb_q <= strobe_cb;
    end

  default clocking cb_main @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  AST_KB_COMPLEMENT: assert property (strobe_kb == !strobe_k)
    else $error("input strobe pair not complementary");
  AST_LOAD_AT_K_RISE: assert property ($fell(load_n) |-> k_rise)
    else $error("load strobe fell away from a k rise");
  AST_WRITE_BURST: assert property (wr_load |-> ##4 (k_rise && ctl_dq_oe) ##2 (kb_rise && ctl_dq_oe))
    else $error("write burst words not on k and kb rises");
  AST_READ_BURST: assert property (rd_load |-> ##5 dev_dq_oe [*4])
    else $error("read burst not driven for both words");
  AST_OE_ONLY_READ: assert property ($rose(dev_dq_oe) |-> $past(rd_load, 5))
    else $error("device drove data without a loaded read");
  AST_NO_CONTENTION: assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data pins");
  AST_DQ_AT_STROBE: assert property ($changed(dev_dq) |-> $past(out_rise))
    else $error("read data moved off an output strobe rise");
  AST_SEL_IDLE: assert property (!ctl_dq_oe |-> &byte_write_sel_n)
    else $error("byte selects active outside a write word");
  AST_NIB_UNUSED: assert property ((DATA_W != DSB_NIBBLE_VARIANT_W) |-> &nibble_write_sel_n)
    else $error("nibble selects active on a byte variant");
  AST_WORD_HOLD: assert property (ctl_dq_oe && !k_rise && !kb_rise |-> $stable(ctl_dq))
    else $error("write word changed between strobe rises");

  CV_WRITE: cover property (wr_load ##4 ctl_dq_oe);
  CV_READ: cover property (rd_load ##5 dev_dq_oe);
  CV_BACK_TO_BACK: cover property (wr_load ##4 wr_load);
endmodule

// file: ddr_sram_two_word_burst_port_bench.sv
/*
  bench: controller and device joined by the link; user side of the
  controller driven, read bursts scored against a memory model.
  assumes small address width so the array is filled quickly.
*/
`timescale 1ns/1ns
module ddr_sram_two_word_burst_port_bench;
  import dsb_pkg::*;
  localparam int AW = 4;
  localparam int DW = DSB_DATA_W;
  localparam int NL = dsb_lanes(DW);
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic single_clock_mode_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [AW-1:0] req_addr_in = '0;
  logic [DW-1:0] req_wdata0_in = '0;
  logic [DW-1:0] req_wdata1_in = '0;
  logic [NL-1:0] req_wsel0_n_in = '1;
  logic [NL-1:0] req_wsel1_n_in = '1;
  logic req_ready_out;
  logic rd_valid_out;
  logic [DW-1:0] rd_data0_out;
  logic [DW-1:0] rd_data1_out;
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [2*DW-1:0] exp_q [$];
  logic [63:0] r;
  int failures = 0;
  int n_compared = 0;
  int i;

  dsb_link_if #(.DATA_W(DW), .ADDR_W(AW)) dsb_link_if_i ();
  dsb_sram_ctl #(.DATA_W(DW), .ADDR_W(AW)) dsb_sram_ctl_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .link(dsb_link_if_i), .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata0_in(req_wdata0_in), .req_wdata1_in(req_wdata1_in), .req_wsel0_n_in(req_wsel0_n_in),
    .req_wsel1_n_in(req_wsel1_n_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data0_out(rd_data0_out), .rd_data1_out(rd_data1_out));
  dsb_sram_dev #(.DATA_W(DW), .ADDR_W(AW)) dsb_sram_dev_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .link(dsb_link_if_i), .single_clock_mode_in(single_clock_mode_in));
  dsb_link_asserts #(.DATA_W(DW)) dsb_link_asserts_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .strobe_k(dsb_link_if_i.strobe_k), .strobe_kb(dsb_link_if_i.strobe_kb), .strobe_c(dsb_link_if_i.strobe_c),
    .strobe_cb(dsb_link_if_i.strobe_cb), .load_n(dsb_link_if_i.load_n),
    .read_not_write(dsb_link_if_i.read_not_write), .nibble_write_sel_n(dsb_link_if_i.nibble_write_sel_n),
    .byte_write_sel_n(dsb_link_if_i.byte_write_sel_n), .ctl_dq(dsb_link_if_i.ctl_dq),
    .ctl_dq_oe(dsb_link_if_i.ctl_dq_oe), .dev_dq(dsb_link_if_i.dev_dq), .dev_dq_oe(dsb_link_if_i.dev_dq_oe));

  initial
  begin
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic end_sim();
    if (exp_q.size() != 0)
      failures++;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // deselected lane keeps the stored nine bits
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] d, input logic [NL-1:0] s);
    merge = old;
    for (int l = 0; l < NL; l++)
      if (!s[l])
        merge[l*DSB_BYTE_W +: DSB_BYTE_W] = d[l*DSB_BYTE_W +: DSB_BYTE_W];
  endfunction

  // valid stays up between calls, so back-to-back requests never re-drive an edge
  task automatic do_req(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
    input logic [NL-1:0] s0, input logic [NL-1:0] s1);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata0_in <= d0;
    req_wdata1_in <= d1;
    req_wsel0_n_in <= s0;
    req_wsel1_n_in <= s1;
    do @(posedge mclk_in); while (req_ready_out !== 1'b1);
    if (w)
    begin
      mem[a] = merge(mem[a], d0, s0);
      mem[a ^ 4'h1] = merge(mem[a ^ 4'h1], d1, s1);
    end
    else
      exp_q.push_back({mem[a], mem[a ^ 4'h1]});
  endtask

  always @(posedge mclk_in)
    if (rd_valid_out === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp_word(rd_data0_out, {DW{1'bx}});
      else
      begin
        cmp_word(rd_data0_out, exp_q[0][2*DW-1:DW]);
        cmp_word(rd_data1_out, exp_q[0][DW-1:0]);
        void'(exp_q.pop_front());
      end
    end

  initial
  begin
    #100000;
    failures++;
    end_sim();
  end

  initial
  begin
    void'($urandom(2748));
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 16; i += 2)
    begin
      r = {$urandom, $urandom};
      do_req(1'b1, AW'(i), r[17:0], r[35:18], 2'h0, 2'h0);
    end
    for (i = 0; i < 30; i++)
    begin
      r = {$urandom, $urandom};
      do_req(1'b1, r[3:0], r[21:4], r[39:22], r[41:40], r[43:42]);
    end
    for (i = 0; i < 16; i++)
      do_req(1'b0, AW'(i), '0, '0, '1, '1);
    single_clock_mode_in <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      r = {$urandom, $urandom};
      do_req(r[44], r[3:0], r[21:4], r[39:22], r[41:40], r[43:42]);
    end
    req_valid_in <= 1'b0;
    repeat (24) @(posedge mclk_in);
    end_sim();
  end
endmodule
